// File: hw/cpfc_defs.vh
// Constants for the clock path frequency configuration block.
// Assumes inclusion by bare name from the hw/ design files.
// Functional notes
// RULE_01 - Redirect bit 1 disables aux digital loop; its detector measures main versus aux.
// RULE_02 - Source select bit routes aux multiplier from aux loop (0) or main loop (1).
// RULE_03 - Main-to-aux rate code 00 gives 98.304 MHz, 01 gives 131.072 MHz.
// RULE_04 - Main-to-aux rate code 10 gives 148.224 MHz, 11 gives 98.816 MHz.
// RULE_05 - Main rate codes 000 to 101 select six rates; 110 and 111 unused.
// RULE_06 - Aux bandwidth register is read/write, resets to zero, bits 7:2 unused.
// RULE_07 - Unused bits ignore writes, read zero; reserved rate codes keep running setting.
`ifndef CPFC_DEFS_VH
`define CPFC_DEFS_VH
`define CPFC_MAIN_CFG_ADDR    8'h00
`define CPFC_AUX_BW_ADDR      8'h04
`define CPFC_MAIN_CFG_RESET   8'h01
`define CPFC_AUX_BW_RESET     8'h00
`define CPFC_MAIN_CFG_MASK    8'hf7
`define CPFC_AUX_BW_MASK      8'h03
`define CPFC_REDIRECT_BIT     7
`define CPFC_SRC_SEL_BIT      6
`define CPFC_AUX_RATE_HI      5
`define CPFC_AUX_RATE_LO      4
`define CPFC_MAIN_RATE_HI     2
`define CPFC_MAIN_RATE_LO     0
`define CPFC_MAIN_RATE_LAST   3'h5
// Rate identifiers driven to the analogue multipliers
`define CPFC_R_77_DIG         3'h0
`define CPFC_R_77_ANA         3'h1
`define CPFC_R_12E1           3'h2
`define CPFC_R_16E1           3'h3
`define CPFC_R_24DS1          3'h4
`define CPFC_R_16DS1          3'h5
`endif

// File: hw/cpfc_rate_map.v
// Maps the two-bit main-to-aux rate field onto a multiplier rate identifier.
// Assumes a static field from the configuration register.
`timescale 1ns/1ps
`default_nettype none
`include "cpfc_defs.vh"
module cpfc_rate_map (
   input  wire [1:0] rate_code,
   output reg  [2:0] rate_id
);
   // Two-bit code covers exactly four telecom rates
   always @* begin
      case (rate_code)
         2'h0:    rate_id = `CPFC_R_12E1;  // 98.304 MHz, see RULE_03
         2'h1:    rate_id = `CPFC_R_16E1;  // 131.072 MHz, see RULE_03
         2'h2:    rate_id = `CPFC_R_24DS1; // 148.224 MHz, see RULE_04
         default: rate_id = `CPFC_R_16DS1; // 98.816 MHz, see RULE_04
      endcase
   end
endmodule // cpfc_rate_map
`default_nettype wire

// File: hw/cpfc_ahb_slave.v
// AHB-Lite slave front end: captures the address phase of single word transfers.
// Assumes one slave on the bus; always zero wait states, always OKAY.
`timescale 1ns/1ps
`default_nettype none
module cpfc_ahb_slave (
   input  wire        sys_clk,
   input  wire        rst_b,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire        hready,
   output reg         wr_pend_reg,
   output reg  [7:0]  addr_reg,
   output wire        rd_now,
   output wire [7:0]  rd_addr,
   output wire        hreadyout,
   output wire        hresp
);
   wire take;
   assign take = hsel & hready & htrans[1];
   // Reads decode in the address phase so data is registered for the data phase
   assign rd_now    = take & ~hwrite;
   assign rd_addr   = haddr[7:0];
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   // Write data arrives one cycle later, so remember the address
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         wr_pend_reg <= 1'b0;
         addr_reg    <= 8'h00;
      end else begin
         wr_pend_reg <= take & hwrite;
         addr_reg    <= haddr[7:0];
      end
   end
endmodule // cpfc_ahb_slave
`default_nettype wire

// File: hw/cpfc_top.v
// Clock path frequency configuration: two registers steering the main and aux paths.
// Assumes a single AHB-Lite master, word accesses, inputs synchronous to sys_clk.
//
// Design decisions made here: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "cpfc_defs.vh"
module cpfc_top (
   input  wire        sys_clk,
   input  wire        rst_b,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output wire        hreadyout,
   output wire        hresp,
   output reg  [2:0]  main_rate_id,
   output reg         main_analogue_feedback,
   output reg         aux_loop_enable,
   output reg         phase_measure_active,
   output reg         aux_multiplier_from_main,
   output reg  [2:0]  aux_multiplier_rate,
   output reg  [1:0]  aux_loop_bandwidth
);
   reg  [7:0] main_cfg_reg;
   reg  [7:0] main_cfg_next;
   reg  [7:0] aux_bw_reg;
   reg  [7:0] aux_bw_next;
   reg  [2:0] run_rate_reg;
   wire       wr_pend;
   wire [7:0] wr_addr;
   wire       rd_now;
   wire [7:0] rd_addr;
   wire [2:0] mapped_rate;
   wire [2:0] new_rate;

   // Register read mux shared by the read path
   function [7:0] reg_view;
      input [7:0] a;
      input [7:0] m;
      input [7:0] b;
      begin
         if (a == `CPFC_MAIN_CFG_ADDR)
            reg_view = m;
         else if (a == `CPFC_AUX_BW_ADDR)
            reg_view = b;
         else
            reg_view = 8'h00;
      end
   endfunction

   cpfc_ahb_slave u_slave (
      .sys_clk     (sys_clk),
      .rst_b       (rst_b),
      .hsel        (hsel),
      .haddr       (haddr),
      .htrans      (htrans),
      .hwrite      (hwrite),
      .hready      (hready),
      .wr_pend_reg (wr_pend),
      .addr_reg    (wr_addr),
      .rd_now      (rd_now),
      .rd_addr     (rd_addr),
      .hreadyout   (hreadyout),
      .hresp       (hresp)
   );

   cpfc_rate_map u_map (
      .rate_code (main_cfg_reg[`CPFC_AUX_RATE_HI:`CPFC_AUX_RATE_LO]),
      .rate_id   (mapped_rate)
   );

   assign new_rate = main_cfg_reg[`CPFC_MAIN_RATE_HI:`CPFC_MAIN_RATE_LO];

   // Write path; unused bits masked so they always read zero
   always @* begin
      main_cfg_next = main_cfg_reg;
      aux_bw_next   = aux_bw_reg;
      if (wr_pend && wr_addr == `CPFC_MAIN_CFG_ADDR)
         main_cfg_next = hwdata[7:0] & `CPFC_MAIN_CFG_MASK; // see RULE_07
      if (wr_pend && wr_addr == `CPFC_AUX_BW_ADDR)
         aux_bw_next = hwdata[7:0] & `CPFC_AUX_BW_MASK;     // see RULE_06
   end

   // Register storage and read data
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         main_cfg_reg <= `CPFC_MAIN_CFG_RESET;
         aux_bw_reg   <= `CPFC_AUX_BW_RESET;                // see RULE_06
         hrdata       <= 32'h00000000;
      end else begin
         main_cfg_reg <= main_cfg_next;
         aux_bw_reg   <= aux_bw_next;
         if (rd_now)
            hrdata <= {24'h000000, reg_view(rd_addr, main_cfg_reg, aux_bw_reg)};
      end
   end

   // Running main rate holds over a reserved code so the loop never sees it
   always @(posedge sys_clk) begin
      if (!rst_b)
         run_rate_reg <= `CPFC_R_77_ANA;
      else if (new_rate <= `CPFC_MAIN_RATE_LAST)
         run_rate_reg <= new_rate;                          // see RULE_05, see RULE_07
   end

   // Path control outputs, registered for clean timing into the analogue blocks
   always @(posedge sys_clk) begin
      if (!rst_b) begin
         main_rate_id             <= `CPFC_R_77_ANA;
         main_analogue_feedback   <= 1'b1;
         aux_loop_enable          <= 1'b1;
         phase_measure_active     <= 1'b0;
         aux_multiplier_from_main <= 1'b0;
         aux_multiplier_rate      <= `CPFC_R_77_DIG;
         aux_loop_bandwidth       <= 2'h0;
      end else begin
         main_rate_id           <= run_rate_reg;            // see RULE_05
         main_analogue_feedback <= (run_rate_reg != `CPFC_R_77_DIG);
         // Redirect turns the aux loop into a phase meter
         aux_loop_enable        <= ~main_cfg_reg[`CPFC_REDIRECT_BIT]; // see RULE_01
         phase_measure_active   <= main_cfg_reg[`CPFC_REDIRECT_BIT];  // see RULE_01
         aux_multiplier_from_main <= main_cfg_reg[`CPFC_SRC_SEL_BIT]; // see RULE_02
         // Rate only meaningful when the main loop drives the aux multiplier
         if (main_cfg_reg[`CPFC_SRC_SEL_BIT])
            aux_multiplier_rate <= mapped_rate;             // see RULE_03, see RULE_04
         else
            aux_multiplier_rate <= `CPFC_R_77_DIG;
         aux_loop_bandwidth     <= aux_bw_reg[1:0];
      end
   end
endmodule // cpfc_top
`default_nettype wire

// File: bench/cpfc_top_sva.sv
// Checker for the clock path configuration block, watching its ports only.
// Assumes one sys_clk domain and writes spaced at least six cycles apart.
`timescale 1ns/1ps
`default_nettype none
module cpfc_chk (
   input wire logic        sys_clk,
   input wire logic        rst_b,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic [2:0]  main_rate_id,
   input wire logic        main_analogue_feedback,
   input wire logic        aux_loop_enable,
   input wire logic        phase_measure_active,
   input wire logic        aux_multiplier_from_main,
   input wire logic [2:0]  aux_multiplier_rate,
   input wire logic [1:0]  aux_loop_bandwidth
);
   // Write address phases to each register; outputs are judged four edges on
   wire w0 = hsel & hready & htrans[1] & hwrite & (haddr[7:0] == 8'h00);
   wire w4 = hsel & hready & htrans[1] & hwrite & (haddr[7:0] == 8'h04);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   AST_EN: assert property (phase_measure_active != aux_loop_enable) else $error("enable");
   AST_RED: assert property (w0 |-> ##4 phase_measure_active == $past(hwdata[7], 3))
      else $error("redirect");
   AST_SRC: assert property (w0 |-> ##4 aux_multiplier_from_main == $past(hwdata[6], 3))
      else $error("source");
   AST_AUX: assert property (w0 |-> ##4 aux_multiplier_rate == ($past(hwdata[6], 3) ?
      3'h2 + {1'b0, $past(hwdata[5:4], 3)} : 3'h0)) else $error("aux rate");
   AST_FB: assert property (main_analogue_feedback == (main_rate_id != 3'h0)) else $error("fb");
   AST_BW: assert property (w4 |-> ##4 aux_loop_bandwidth == $past(hwdata[1:0], 3))
      else $error("bandwidth");
   AST_HI: assert property (hrdata[31:8] == 24'h0) else $error("upper read bits");
   AST_RNG: assert property (main_rate_id <= 3'h5) else $error("rate range");
endmodule // cpfc_chk
bind cpfc_top cpfc_chk u_chk (.sys_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hwdata,
   .hready, .hrdata, .main_rate_id, .main_analogue_feedback, .aux_loop_enable,
   .phase_measure_active, .aux_multiplier_from_main, .aux_multiplier_rate, .aux_loop_bandwidth);
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench: random register traffic over AHB-Lite, outputs compared.
// Assumes the checker is bound to cpfc_top elsewhere; one 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic sys_clk = 0, rst_b = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, lf = 32'h27c581ee, r;
   logic [1:0] htrans = 0, aux_loop_bandwidth;
   logic [2:0] hsize = 3'h2, main_rate_id, aux_multiplier_rate, er = 3'h1;
   logic main_analogue_feedback, aux_loop_enable, phase_measure_active, aux_multiplier_from_main;
   logic [7:0] em = 8'h01, eb = 8'h00, a;
   int bad_count = 0, n_compared = 0;
   // Single slave, so its ready drives the bus ready
   cpfc_top DUT (.sys_clk, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .main_rate_id, .main_analogue_feedback,
      .aux_loop_enable, .phase_measure_active, .aux_multiplier_from_main, .aux_multiplier_rate,
      .aux_loop_bandwidth);
   initial forever #5 sys_clk = ~sys_clk;
   function automatic logic [31:0] nxt(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // Reserved main codes never reach the running rate, so it is tracked apart
   function automatic logic [31:0] eo(input logic [7:0] m, b, input logic [2:0] rt);
      return {20'h0, rt, rt != 3'h0, ~m[7], m[7], m[6], m[6] ? 3'h2 + {1'b0, m[5:4]} : 3'h0, b[1:0]};
   endfunction
   task summarize;
      $display("compared %0d wrong %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] g, e);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // Bounded wait for ready; a hung bus ends the run
   task hwait;
      int k;
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (hreadyout !== 1'b1 && k < 20);
      if (hreadyout !== 1'b1) begin
         bad_count++;
         summarize;
      end
   endtask
   task xfer(input logic w, input logic [7:0] ad, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, ad};
      hwait;
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      hwait;
      r = hrdata;
      chk({31'h0, hresp}, 32'h0); // Single slave always answers OKAY
   endtask
   task outs;
      chk({20'h0, main_rate_id, main_analogue_feedback, aux_loop_enable, phase_measure_active,
         aux_multiplier_from_main, aux_multiplier_rate, aux_loop_bandwidth}, eo(em, eb, er));
   endtask
   // First eight writes walk every main rate code, then random addresses incl. unmapped
   initial begin
      repeat (5) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      xfer(1'b0, 8'h00, 32'h0);
      chk(r, 32'h01);
      xfer(1'b0, 8'h04, 32'h0);
      chk(r, 32'h0);
      outs;
      for (int i = 0; i < 40; i++) begin
         lf = nxt(lf);
         a = (i < 8) ? 8'h00 : (lf[8] ? 8'h04 : (lf[9] ? 8'h08 : 8'h00));
         if (i < 8)
            lf[2:0] = i[2:0];
         xfer(1'b1, a, lf);
         if (a == 8'h00) begin
            em = lf[7:0] & 8'hf7;
            er = (lf[2:0] <= 3'h5) ? lf[2:0] : er;
         end
         if (a == 8'h04)
            eb = lf[7:0] & 8'h03;
         repeat (4) @(posedge sys_clk);
         outs;
         xfer(1'b0, a, 32'h0);
         chk(r, (a == 8'h00) ? {24'h0, em} : (a == 8'h04) ? {24'h0, eb} : 32'h0);
         $display("test %0d done", i);
      end
      // Mid-run reset must bring both registers and all outputs back
      rst_b <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      em = 8'h01;
      eb = 8'h00;
      er = 3'h1;
      outs;
      xfer(1'b0, 8'h00, 32'h0);
      chk(r, 32'h01);
      xfer(1'b0, 8'h04, 32'h0);
      chk(r, 32'h0);
      $display("test reset done");
      summarize;
   end
endmodule // tb
`default_nettype wire
